//--- rtl/swc_pkg.sv
`default_nettype none
package swc_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned MS_PER_S = 1000;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GC3 = 8'h05;
    localparam logic [7:0] IDX_GC4 = 8'h06;
    localparam logic [7:0] IDX_GC5 = 8'h07;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_GC3 = {IDX_GC3[5:0], 2'h0};
    localparam logic [7:0] ADDR_GC4 = {IDX_GC4[5:0], 2'h0};
    localparam logic [7:0] ADDR_GC5 = {IDX_GC5[5:0], 2'h0};

    // First control register fields
    localparam int GC3_VLAN = 7;
    localparam int GC3_IGMP = 6;
    localparam int GC3_MLD = 5;
    localparam int GC3_MLD_OPT = 4;
    localparam int GC3_WFQ = 3;
    localparam int GC3_SNIFF_AND = 0;
    // Second control register fields
    localparam int GC4_REPEATER = 7;
    localparam int GC4_HALF = 6;
    localparam int GC4_PAUSE = 5;
    localparam int GC4_TEN = 4;
    localparam int GC4_NULL_VID = 3;
    localparam int GC4_STORM_HI = 2;

    localparam logic [7:0] GC3_RST = 8'h00;
    localparam logic [7:0] GC4_RST = 8'h00;
    localparam logic [7:0] GC5_RST = 8'h63;

    // Strap bit order in the synchroniser vector
    localparam int STRAP_DUPLEX = 0;
    localparam int STRAP_PAUSE = 1;
    localparam int STRAP_SPEED = 2;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Queue weights q3..q0
    localparam logic [3:0][3:0] WFQ_WEIGHT = {4'h8, 4'h4, 4'h2, 4'h1};
    localparam logic [3:0] WFQ_BONUS = 4'h1;

    localparam int VID_W = 12;
    localparam logic [11:0] NULL_VID = 12'h000;
    localparam int STORM_W = 11;

    localparam int unsigned INTERVAL_100_MS = 67;
    localparam int unsigned INTERVAL_10_MS = 500;
    localparam int unsigned INTERVAL_100_CYC =
        INTERVAL_100_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned INTERVAL_10_CYC =
        INTERVAL_10_MS * (CLK_HZ / MS_PER_S);
    localparam int TICK_W = 25;
endpackage
`default_nettype wire

//--- rtl/swc_global_ctrl.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`default_nettype none
module swc_global_ctrl
    import swc_pkg::*;
#(
    parameter int unsigned P_INTERVAL_100_CYC = swc_pkg::INTERVAL_100_CYC,
    parameter int unsigned P_INTERVAL_10_CYC = swc_pkg::INTERVAL_10_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [swc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic DUPLEX_STRAP_PIN,
    input wire logic PAUSE_STRAP_PIN,
    input wire logic SPEED_STRAP_PIN,
    input wire logic [3:0] QUEUE_NONEMPTY,
    input wire logic TX_REQ,
    output logic [1:0] GRANT,
    output logic GRANT_VALID,
    input wire logic SNIFF_SRC_HIT,
    input wire logic SNIFF_DST_HIT,
    output logic MIRROR,
    input wire logic IS_IGMP,
    output logic IGMP_TO_HOST,
    input wire logic [swc_pkg::VID_W-1:0] VID_IN,
    input wire logic [swc_pkg::VID_W-1:0] PORT_VID,
    output logic [swc_pkg::VID_W-1:0] VID_OUT,
    output logic VLAN_EN,
    output logic MLD_EN,
    output logic MLD_OPT,
    output logic WFQ_EN,
    output logic REPEATER_EN,
    output logic HOST_HALF_DUPLEX,
    output logic HOST_PAUSE_EN,
    output logic HOST_10M,
    output logic NULL_VID_EN,
    output logic [swc_pkg::STORM_W-1:0] STORM_LIMIT,
    output logic STORM_TICK
);
    import swc_pkg::*;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [1:0] settle;
        logic loaded;
        logic pend;
        logic [7:0] rdata;
        logic [7:0] gc3;
        logic [7:0] gc4;
        logic [7:0] gc5;
        logic [3:0][3:0] credit;
        logic [1:0] grant;
        logic grant_vld;
        logic mirror;
        logic igmp_host;
        logic [VID_W-1:0] vid_out;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
    } swc_state_s;

    swc_state_s st;
    swc_state_s next_st;

    function automatic logic [1:0] swc_top(input logic [3:0] v);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (v[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic req;
    logic hit_gc3;
    logic hit_gc4;
    logic hit_gc5;
    logic wr_go;
    logic [1:0] top_q;
    logic any_empty;
    logic [3:0] has_credit;
    logic [3:0][3:0] refill;
    logic [TICK_W-1:0] period;

    assign req = AVS_READ | AVS_WRITE;
    assign hit_gc3 = (AVS_ADDRESS == ADDR_GC3);
    assign hit_gc4 = (AVS_ADDRESS == ADDR_GC4);
    assign hit_gc5 = (AVS_ADDRESS == ADDR_GC5);
    assign wr_go = AVS_WRITE & st.pend & AVS_BYTEENABLE[0];
    assign top_q = swc_top(QUEUE_NONEMPTY);
    assign any_empty = ~&QUEUE_NONEMPTY;
    // Waits until straps are loaded, then answers on the second cycle
    assign AVS_WAITREQUEST = req & ~st.pend;
    assign AVS_READDATA = {24'h000000, st.rdata};
    assign period = st.gc4[GC4_TEN] ? TICK_W'(P_INTERVAL_10_CYC)
                                    : TICK_W'(P_INTERVAL_100_CYC);

    // Refill per queue: empty queues get nothing, top may get a bonus
    genvar q;
    generate
        for (q = 0; q < 4; q++) begin : g_queue
            assign has_credit[q] = QUEUE_NONEMPTY[q] &&
                                   (st.credit[q] != 4'h0);
            assign refill[q] = !QUEUE_NONEMPTY[q] ? 4'h0 :
                ((2'(q) == top_q && any_empty) ? WFQ_WEIGHT[q] + WFQ_BONUS
                                               : WFQ_WEIGHT[q]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [3:0][3:0] cr;
        logic [1:0] pick;
        cr = st.credit;
        pick = 2'h0;
        next_st = st;

        next_st.sync1 = {SPEED_STRAP_PIN, PAUSE_STRAP_PIN, DUPLEX_STRAP_PIN};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;

        // Straps are taken only once two stages agree after release
        // Loaded once, so a wandering pin cannot undo a software write
        if (!st.loaded) begin
            if (st.settle != STRAP_SETTLE) begin
                next_st.settle = st.settle + 2'h1;
            end else if (st.sync2 == st.sync3) begin
                next_st.loaded = 1'b1;
                next_st.gc4[GC4_HALF] = st.sync3[STRAP_DUPLEX];
                next_st.gc4[GC4_PAUSE] = st.sync3[STRAP_PAUSE];
                next_st.gc4[GC4_TEN] = st.sync3[STRAP_SPEED];
            end
        end

        // Avalon slave; unmapped reads give zero, writes are dropped
        next_st.pend = req & ~st.pend & st.loaded;
        if (req && !st.pend && st.loaded) begin
            next_st.rdata = hit_gc3 ? st.gc3 :
                            hit_gc4 ? st.gc4 :
                            hit_gc5 ? st.gc5 : 8'h00;
        end
        if (wr_go && hit_gc3) begin
            next_st.gc3 = AVS_WRITEDATA[7:0];
        end
        if (wr_go && hit_gc4) begin
            next_st.gc4 = AVS_WRITEDATA[7:0];
        end
        if (wr_go && hit_gc5) begin
            next_st.gc5 = AVS_WRITEDATA[7:0];
        end

        // Egress scheduler
        next_st.grant_vld = 1'b0;
        if (TX_REQ && (|QUEUE_NONEMPTY)) begin
            next_st.grant_vld = 1'b1;
            if (!st.gc3[GC3_WFQ]) begin
                pick = top_q;
            end else begin
                if (!(|has_credit)) begin
                    cr = refill;
                end
                for (int i = 0; i < 4; i++) begin
                    if (QUEUE_NONEMPTY[i] && cr[i] != 4'h0) begin
                        pick = 2'(i);
                    end
                end
                cr[pick] = cr[pick] - 4'h1;
                next_st.credit = cr;
            end
            next_st.grant = pick;
        end

        if (st.gc3[GC3_SNIFF_AND]) begin
            next_st.mirror = SNIFF_SRC_HIT & SNIFF_DST_HIT;
        end else begin
            next_st.mirror = SNIFF_SRC_HIT | SNIFF_DST_HIT;
        end
        next_st.igmp_host = IS_IGMP & st.gc3[GC3_IGMP];
        if (st.gc4[GC4_NULL_VID] && VID_IN == NULL_VID) begin
            next_st.vid_out = PORT_VID;
        end else begin
            next_st.vid_out = VID_IN;
        end

        // Storm window follows the host port speed
        next_st.tick = 1'b0;
        if (st.tick_cnt >= period - TICK_W'(1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.gc3 <= GC3_RST;
            st.gc4 <= GC4_RST;
            st.gc5 <= GC5_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign VLAN_EN = st.gc3[GC3_VLAN];
    assign MLD_EN = st.gc3[GC3_MLD];
    assign MLD_OPT = st.gc3[GC3_MLD_OPT];
    assign WFQ_EN = st.gc3[GC3_WFQ];
    assign REPEATER_EN = st.gc4[GC4_REPEATER];
    assign HOST_HALF_DUPLEX = st.gc4[GC4_HALF];
    assign HOST_PAUSE_EN = st.gc4[GC4_PAUSE];
    assign HOST_10M = st.gc4[GC4_TEN];
    assign NULL_VID_EN = st.gc4[GC4_NULL_VID];
    assign STORM_LIMIT = {st.gc4[GC4_STORM_HI:0], st.gc5};
    assign GRANT = st.grant;
    assign GRANT_VALID = st.grant_vld;
    assign MIRROR = st.mirror;
    assign IGMP_TO_HOST = st.igmp_host;
    assign VID_OUT = st.vid_out;
    assign STORM_TICK = st.tick;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_vlan_write: assert property (wr_go && hit_gc3 |=>
        VLAN_EN == $past(AVS_WRITEDATA[7]))
        else $error("vlan enable did not follow write");
    a_igmp_redirect: assert property (IS_IGMP && st.gc3[GC3_IGMP]
        |=> IGMP_TO_HOST) else $error("igmp not sent to host");
    a_igmp_off: assert property (!st.gc3[GC3_IGMP] |=> !IGMP_TO_HOST)
        else $error("igmp redirected while off");
    a_mld_write: assert property (wr_go && hit_gc3 |=>
        MLD_EN == $past(AVS_WRITEDATA[5]) &&
        MLD_OPT == $past(AVS_WRITEDATA[4]))
        else $error("mld bits did not follow write");
    a_strict_grant: assert property (TX_REQ && |QUEUE_NONEMPTY &&
        !WFQ_EN |=> GRANT_VALID && GRANT == $past(top_q))
        else $error("strict priority grant wrong");
    a_wfq_refill: assert property (TX_REQ && WFQ_EN &&
        QUEUE_NONEMPTY == 4'hf && !(|has_credit) |=>
        GRANT == 2'h3 && st.credit[3] == 4'h7 && st.credit[0] == 4'h1)
        else $error("full refill weights wrong");
    a_wfq_bonus: assert property (TX_REQ && WFQ_EN &&
        QUEUE_NONEMPTY == 4'hb && !(|has_credit) |=>
        st.credit[3] == 4'h8 && st.credit[2] == 4'h0)
        else $error("bonus weight wrong");
    a_sniff_and: assert property (st.gc3[GC3_SNIFF_AND] &&
        SNIFF_SRC_HIT && !SNIFF_DST_HIT |=> !MIRROR)
        else $error("and sniff mirrored on one match");
    a_sniff_or: assert property (!st.gc3[GC3_SNIFF_AND] &&
        (SNIFF_SRC_HIT || SNIFF_DST_HIT) |=> MIRROR)
        else $error("or sniff missed a match");
    a_strap_load: assert property ($rose(st.loaded) |->
        HOST_HALF_DUPLEX == $past(st.sync3[STRAP_DUPLEX]) &&
        HOST_PAUSE_EN == $past(st.sync3[STRAP_PAUSE]) &&
        HOST_10M == $past(st.sync3[STRAP_SPEED]))
        else $error("strap value not loaded");
    a_null_vid: assert property (NULL_VID_EN && VID_IN == NULL_VID
        |=> VID_OUT == $past(PORT_VID)) else $error("null vid kept");
    a_storm_reset: assert property ($rose(st.loaded) |->
        STORM_LIMIT == {GC4_RST[GC4_STORM_HI:0], GC5_RST})
        else $error("storm default wrong");
    a_bus_answer: assert property (req && AVS_WAITREQUEST && st.loaded
        |=> !AVS_WAITREQUEST) else $error("bus answer late");
    a_no_grant: assert property (!(TX_REQ && |QUEUE_NONEMPTY) |=>
        !GRANT_VALID) else $error("grant without request");
    a_gc4_write: assert property (wr_go && hit_gc4 |=>
        {REPEATER_EN, HOST_HALF_DUPLEX, HOST_PAUSE_EN, HOST_10M,
        NULL_VID_EN} == $past(AVS_WRITEDATA[GC4_REPEATER:GC4_NULL_VID]))
        else $error("host port bits did not follow write");
    a_storm_write: assert property (wr_go && hit_gc5 |=>
        STORM_LIMIT[7:0] == $past(AVS_WRITEDATA[7:0]))
        else $error("storm low byte did not follow write");
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic duplex_strap = 1'b1;
    logic pause_strap = 1'b0;
    logic speed_strap = 1'b1;
    logic [3:0] queue_nonempty = 4'h0;
    logic tx_req = 1'b0;
    logic [1:0] grant;
    logic grant_valid, sniff_src = 1'b0, sniff_dst = 1'b0, mirror;
    logic is_igmp = 1'b0, igmp_to_host;
    logic [11:0] vid_in = 12'h0, port_vid = 12'h5a3, vid_out;
    logic vlan_en, mld_en, mld_opt, wfq_en, repeater_en;
    logic host_half, host_pause, host_10m, null_vid_en, storm_tick;
    logic [10:0] storm_limit;
    logic [7:0] rd;
    logic [7:0] cnt [4];
    int err_count = 0;
    int tests_run = 0;
    int gap;

    always #12.5 clk_sys = ~clk_sys;

    // Short windows keep the tick checks inside the run budget
    swc_global_ctrl #(.P_INTERVAL_100_CYC(20), .P_INTERVAL_10_CYC(50)) i_dut (
        .CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .DUPLEX_STRAP_PIN(duplex_strap), .PAUSE_STRAP_PIN(pause_strap),
        .SPEED_STRAP_PIN(speed_strap), .QUEUE_NONEMPTY(queue_nonempty),
        .TX_REQ(tx_req), .GRANT(grant), .GRANT_VALID(grant_valid),
        .SNIFF_SRC_HIT(sniff_src), .SNIFF_DST_HIT(sniff_dst),
        .MIRROR(mirror), .IS_IGMP(is_igmp), .IGMP_TO_HOST(igmp_to_host),
        .VID_IN(vid_in), .PORT_VID(port_vid), .VID_OUT(vid_out),
        .VLAN_EN(vlan_en), .MLD_EN(mld_en), .MLD_OPT(mld_opt),
        .WFQ_EN(wfq_en), .REPEATER_EN(repeater_en),
        .HOST_HALF_DUPLEX(host_half), .HOST_PAUSE_EN(host_pause),
        .HOST_10M(host_10m), .NULL_VID_EN(null_vid_en),
        .STORM_LIMIT(storm_limit), .STORM_TICK(storm_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        for (n = 0; n < 100; n++) begin
            #1;
            if (avs_waitrequest === 1'b0) break;
            @(posedge clk_sys);
        end
        if (n == 100) begin
            chk("bus timeout", 32'h1, 32'h0);
            end_of_test();
        end
        @(posedge clk_sys);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    task automatic tick_gap(output int g);
        int n;
        g = 0;
        for (n = 0; n < 200 && storm_tick !== 1'b1; n++) step();
        for (g = 1; g < 200; g++) begin
            step();
            if (storm_tick === 1'b1) break;
        end
        if (n == 200 || g == 200) begin
            chk("tick timeout", 32'h1, 32'h0);
            end_of_test();
        end
    endtask

    // Back-to-back requests; grants are tallied per queue
    task automatic send(input logic [3:0] ne, input int n);
        int i;
        for (i = 0; i < 4; i++) cnt[i] = 8'h0;
        @(posedge clk_sys);
        queue_nonempty <= ne;
        for (i = 0; i <= n; i++) begin
            @(posedge clk_sys);
            tx_req <= (i < n);
            #1;
            if (grant_valid === 1'b1) cnt[grant]++;
        end
    endtask

    task automatic sniff_all(input logic mode);
        int i;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            sniff_src <= i[1];
            sniff_dst <= i[0];
            step();
            chk("mirror", mirror,
                mode ? (i[1] & i[0]) : (i[1] | i[0]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        bus(1'b0, ADDR_GC3, 8'h00, 4'h0);
        chk("gc3 reset", rd, 8'h00);
        bus(1'b0, ADDR_GC4, 8'h00, 4'h0);
        chk("gc4 reset", rd, 8'h50);
        bus(1'b0, ADDR_GC5, 8'h00, 4'h0);
        chk("gc5 reset", rd, 8'h63);
        chk("cfg", {host_half, host_pause, host_10m}, 3'b101);
        chk("storm limit", storm_limit, 11'h063);
        tick_gap(gap);
        tick_gap(gap);
        chk("window 10", gap, 50);
        $display("Test reset and straps done");

        bus(1'b1, ADDR_GC4, 8'h00, 4'h1);
        tick_gap(gap);
        tick_gap(gap);
        chk("window 100", gap, 20);
        bus(1'b1, ADDR_GC3, 8'hf9, 4'h1);
        bus(1'b1, ADDR_GC4, 8'haf, 4'h1);
        bus(1'b1, ADDR_GC5, 8'h12, 4'h1);
        bus(1'b1, ADDR_GC3, 8'h00, 4'h0);
        bus(1'b1, 8'h20, 8'h5a, 4'h1);
        bus(1'b0, 8'h20, 8'h00, 4'h0);
        chk("unmapped", rd, 8'h00);
        bus(1'b0, ADDR_GC3, 8'h00, 4'h0);
        chk("gc3 rw", rd, 8'hf9);
        bus(1'b0, ADDR_GC4, 8'h00, 4'h0);
        chk("gc4 rw", rd, 8'haf);
        chk("gc3 out", {vlan_en, mld_en, mld_opt, wfq_en}, 4'hf);
        chk("gc4 out", {repeater_en, host_half, host_pause, host_10m,
            null_vid_en}, 5'b10101);
        chk("storm hi", storm_limit, 11'h712);
        $display("Test register access done");

        @(posedge clk_sys);
        is_igmp <= 1'b1;
        vid_in <= 12'h000;
        step();
        chk("igmp on", igmp_to_host, 1'b1);
        chk("vid swap", vid_out, 12'h5a3);
        @(posedge clk_sys);
        vid_in <= 12'h123;
        step();
        chk("vid keep", vid_out, 12'h123);
        sniff_all(1'b1);
        bus(1'b1, ADDR_GC3, 8'h00, 4'h1);
        bus(1'b1, ADDR_GC4, 8'h00, 4'h1);
        @(posedge clk_sys);
        vid_in <= 12'h000;
        step();
        chk("igmp off", igmp_to_host, 1'b0);
        chk("vid off", vid_out, 12'h000);
        sniff_all(1'b0);
        $display("Test forwarding controls done");

        send(4'h6, 3);
        chk("strict", {cnt[3], cnt[2], cnt[1], cnt[0]}, 32'h00030000);
        send(4'h0, 2);
        chk("empty", {cnt[3], cnt[2], cnt[1], cnt[0]}, 32'h0);
        @(posedge clk_sys);
        duplex_strap <= 1'b0;
        pause_strap <= 1'b1;
        speed_strap <= 1'b0;
        do_reset();
        bus(1'b0, ADDR_GC4, 8'h00, 4'h0);
        chk("gc4 restrap", rd, 8'h20);
        bus(1'b1, ADDR_GC3, 8'h08, 4'h1);
        send(4'hf, 15);
        chk("wfq full", {cnt[3], cnt[2], cnt[1], cnt[0]}, 32'h08040201);
        do_reset();
        bus(1'b1, ADDR_GC3, 8'h08, 4'h1);
        send(4'hb, 12);
        chk("wfq bonus", {cnt[3], cnt[2], cnt[1], cnt[0]}, 32'h09000201);
        $display("Test scheduler done");
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        chk("run timeout", 32'h1, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
